//--- hw/bals_pkg.sv
// constants, field layouts and carrier types for the byte alu slice
// assumes an apb master with 32-bit data and word aligned addresses
package bals_pkg;

  localparam int             DATA_W     = 8;
  localparam int             REG_AW     = 7;
  localparam int             REG_DEPTH  = 128;
  localparam int             PADDR_W    = 12;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0]    OFS_CMD      = 12'h000;
  localparam logic [11:0]    OFS_ACC      = 12'h004;
  localparam logic [11:0]    OFS_STATUS   = 12'h008;
  localparam logic [11:0]    OFS_REG_IDX  = 12'h00C;
  localparam logic [11:0]    OFS_REG_DATA = 12'h010;
  localparam logic [11:0]    OFS_RESULT   = 12'h014;

  ////////////////////////////////////////////////////////////////////////////
  // command word fields
  localparam int             CMD_OP_LSB   = 0;
  localparam int             CMD_DEST_BIT = 4;
  localparam int             CMD_ADDR_LSB = 8;
  localparam int             CMD_IMM_LSB  = 16;

  // status byte fields: flags low, two held bits, bank select high
  localparam int             ST_C_BIT     = 0;
  localparam int             ST_DC_BIT    = 1;
  localparam int             ST_Z_BIT     = 2;
  localparam int             ST_HELD_LSB  = 3;
  localparam int             ST_BANK_LSB  = 5;
  localparam int             RES_DEST_BIT = 8;

  localparam logic [7:0]     ACC_RST      = 8'h00;
  localparam logic [1:0]     HELD_RST     = 2'b11;
  localparam logic [2:0]     BANK_RST     = 3'b000;
  localparam logic [7:0]     ZERO_BYTE    = 8'h00;
  localparam logic [31:0]    ZERO_WORD    = 32'h0000_0000;
  localparam logic           DEST_ACC     = 1'b0;
  localparam logic           DEST_REG     = 1'b1;

  typedef enum logic [1:0] {
    subtract_acc_from_register,
    xor_acc_with_register,
    nibble_exchange_register,
    xor_immediate_into_acc
  } bals_op_t;

  typedef struct packed {
    logic z;
    logic nibble_borrow_flag;
    logic c;
  } bals_flags_t;

  typedef struct packed {
    bals_op_t            op;
    logic                dest;
    logic [REG_AW-1:0]   addr;
    logic [DATA_W-1:0]   imm;
  } bals_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0]   value;
    logic                to_acc;
    logic                to_reg;
    bals_flags_t         flags;
  } bals_res_t;

endpackage : bals_pkg

//--- hw/bals_regmem.sv
// register file memory for the alu slice, one port, registered read data
// assumes the caller holds write enable for one cycle per write
`timescale 1ns/1ns
`default_nettype none
module bals_regmem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output var  logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || (2**AW) < DEPTH || WIDTH < 1)
  begin : g_bad_size
    $error("DEPTH must be at least 2 and fit the AW address bits");
  end

  // contents are not reset, as in any register ram
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[addr];
    end
  end

endmodule : bals_regmem
`default_nettype wire

//--- hw/bals_alu.sv
// combinational result and flag logic of the byte alu slice
// assumes operand is the addressed register's current value
`timescale 1ns/1ns
`default_nettype none
module bals_alu (
  input  wire bals_pkg::bals_cmd_t   cmd,
  input  wire logic [7:0]            acc,
  input  wire logic [7:0]            operand,
  input  wire bals_pkg::bals_flags_t flags_in,
  output var  bals_pkg::bals_res_t   res
);
  import bals_pkg::*;

  wire logic [7:0] diff     = operand - acc;
  wire logic       no_borrow = (acc <= operand);
  wire logic       nib_ok   = (acc[3:0] <= operand[3:0]);
  wire logic [7:0] xr_reg   = acc ^ operand;
  wire logic [7:0] xr_imm   = acc ^ cmd.imm;
  wire logic [7:0] swapped  = {operand[3:0], operand[7:4]};
  wire logic       to_reg   = (cmd.dest == DEST_REG);

  always_comb
  begin
    res        = '0;
    res.flags  = flags_in;
    res.to_reg = to_reg;
    res.to_acc = !to_reg;
    unique case (cmd.op)
      subtract_acc_from_register:
      begin
        res.value                    = diff;
        res.flags.c                  = no_borrow;
        res.flags.nibble_borrow_flag = nib_ok;
        res.flags.z                  = (diff == ZERO_BYTE);
      end
      xor_acc_with_register:
      begin
        res.value   = xr_reg;
        res.flags.z = (xr_reg == ZERO_BYTE);
      end
      nibble_exchange_register:
      begin
        res.value = swapped;
      end
      xor_immediate_into_acc:
      begin
        res.value   = xr_imm;
        res.to_acc  = 1'b1;
        res.to_reg  = 1'b0;
        res.flags.z = (xr_imm == ZERO_BYTE);
      end
    endcase
  end

endmodule : bals_alu
`default_nettype wire

//--- hw/bals_top.sv
// apb front end, accumulator, status byte and sequencing of the alu slice
// assumes an apb master that holds each request until pready is seen
`timescale 1ns/1ns
`default_nettype none
module bals_top #(
  parameter int REG_DEPTH = bals_pkg::REG_DEPTH
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [bals_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output var  logic                         pready,
  output var  logic [31:0]                  prdata,
  output var  logic                         pslverr
);
  import bals_pkg::*;

  localparam int MEM_AW = $clog2(REG_DEPTH);

  // the 7-bit register address cannot reach beyond 128 entries
  if (REG_DEPTH < 2 || REG_DEPTH > 2**REG_AW || (2**MEM_AW) != REG_DEPTH)
  begin : g_bad_depth
    $error("REG_DEPTH must be a power of two from 2 to 128");
  end

  // every register offset must be reachable on the address bus
  if ((2**PADDR_W) <= OFS_RESULT)
  begin : g_bad_paddr
    $error("PADDR_W is too narrow for the register map");
  end

  typedef enum logic {S_IDLE, S_EXEC} bals_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // state

  bals_state_t       state_r;
  bals_state_t       state_nxt;
  logic [7:0]        acc_r;
  bals_flags_t       flags_r;
  logic [2:0]        bank_r;
  logic [REG_AW-1:0] reg_idx_r;
  bals_cmd_t         cmd_r;
  logic              is_data_r;
  logic              data_wr_r;
  logic [7:0]        data_wdata_r;
  logic [7:0]        last_val_r;
  logic              last_dest_r;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire logic access    = psel && penable && !pready;
  wire logic idle_acc  = access && (state_r == S_IDLE);
  wire logic hit_cmd   = (paddr == OFS_CMD);
  wire logic hit_acc   = (paddr == OFS_ACC);
  wire logic hit_stat  = (paddr == OFS_STATUS);
  wire logic hit_idx   = (paddr == OFS_REG_IDX);
  wire logic hit_data  = (paddr == OFS_REG_DATA);
  wire logic hit_res   = (paddr == OFS_RESULT);
  wire logic mapped    = hit_cmd || hit_acc || hit_stat || hit_idx || hit_data || hit_res;

  // a command read is harmless and returns zero; only a write issues one
  wire logic start_cmd  = idle_acc && hit_cmd && pwrite;
  wire logic start_data = idle_acc && hit_data;
  wire logic go_exec    = start_cmd || start_data;
  wire logic quick_ans  = idle_acc && !go_exec;

  wire bals_cmd_t new_cmd = '{
    op:   bals_op_t'(pwdata[CMD_OP_LSB +: 2]),
    dest: pwdata[CMD_DEST_BIT],
    addr: pwdata[CMD_ADDR_LSB +: REG_AW],
    imm:  pwdata[CMD_IMM_LSB +: DATA_W]
  };

  // a register file access rides the exec cycle as a dummy command
  wire bals_cmd_t data_cmd = '{
    op:   subtract_acc_from_register,
    dest: DEST_ACC,
    addr: reg_idx_r,
    imm:  ZERO_BYTE
  };

  ////////////////////////////////////////////////////////////////////////////
  // register file and alu

  // the register file is addressed from the request while idle, so its
  // read data is ready when exec starts one cycle later
  wire logic [REG_AW-1:0] pick_addr = hit_cmd ? new_cmd.addr : reg_idx_r;
  wire logic [REG_AW-1:0] mem_addr7 = (state_r == S_IDLE) ? pick_addr : cmd_r.addr;
  wire logic [MEM_AW-1:0] mem_addr  = mem_addr7[MEM_AW-1:0];
  logic      [7:0]        mem_rdata;
  bals_res_t              alu_res;

  wire logic exec      = (state_r == S_EXEC);
  wire logic exec_op   = exec && !is_data_r;
  wire logic op_to_reg = exec_op && alu_res.to_reg;
  wire logic op_to_acc = exec_op && alu_res.to_acc;
  wire logic mem_we    = op_to_reg || (exec && is_data_r && data_wr_r);
  wire logic [7:0] mem_wdata = is_data_r ? data_wdata_r : alu_res.value;

  bals_regmem #(
    .DEPTH (REG_DEPTH),
    .WIDTH (DATA_W),
    .AW    (MEM_AW)
  ) bals_regmem_inst (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  bals_alu bals_alu_inst (
    .cmd      (cmd_r),
    .acc      (acc_r),
    .operand  (mem_rdata),
    .flags_in (flags_r),
    .res      (alu_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data selection

  wire logic [7:0] status_byte = {bank_r, HELD_RST, flags_r.z,
                                  flags_r.nibble_borrow_flag, flags_r.c};
  wire logic [31:0] result_word = {23'h00_0000, last_dest_r, last_val_r};
  wire logic [31:0] quick_rd =
      hit_acc  ? {24'h00_0000, acc_r}                       :
      hit_stat ? {24'h00_0000, status_byte}                 :
      hit_idx  ? {25'h000_0000, reg_idx_r}                  :
      hit_res  ? result_word                                :
                 ZERO_WORD;

  // register file read data only stands in the exec cycle, one clock late
  wire logic        data_rd   = exec && is_data_r && !data_wr_r;
  wire logic [31:0] data_word = {24'h00_0000, mem_rdata};
  wire logic [31:0] prdata_nxt =
      quick_ans ? (pwrite ? ZERO_WORD : quick_rd) :
      data_rd   ? data_word                       :
                  ZERO_WORD;

  wire logic wr_quick = quick_ans && pwrite;
  wire logic unmapped = quick_ans && !mapped;
  wire logic sw_acc   = wr_quick && hit_acc;
  wire logic sw_stat  = wr_quick && hit_stat;
  wire logic sw_idx   = wr_quick && hit_idx;

  // software writes to status lose against the alu only in exec, which
  // never overlaps a bus write because the bus is stalled meanwhile
  wire bals_flags_t sw_flags = '{
    z:                  pwdata[ST_Z_BIT],
    nibble_borrow_flag: pwdata[ST_DC_BIT],
    c:                  pwdata[ST_C_BIT]
  };

  // exec lasts one cycle, so the bus answer follows it at once
  always_comb
  begin
    state_nxt = S_IDLE;
    unique case (state_r)
      S_IDLE: state_nxt = go_exec ? S_EXEC : S_IDLE;
      S_EXEC: state_nxt = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and bus answer

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // pready is a one-cycle pulse and the access term excludes the cycle in
  // which it is high, so a request held over the answer is not taken twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= ZERO_WORD;
    end
    else
    begin
      pready  <= quick_ans || exec;
      pslverr <= unmapped;
      prdata  <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_r <= '0;
    end
    else if (go_exec)
    begin
      cmd_r <= hit_cmd ? new_cmd : data_cmd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      is_data_r    <= 1'b0;
      data_wr_r    <= 1'b0;
      data_wdata_r <= ZERO_BYTE;
    end
    else if (go_exec)
    begin
      is_data_r    <= hit_data;
      data_wr_r    <= pwrite;
      data_wdata_r <= pwdata[DATA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator, status and result

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= ACC_RST;
    end
    else if (op_to_acc)
    begin
      acc_r <= alu_res.value;
    end
    else if (sw_acc)
    begin
      acc_r <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= '0;
    end
    else if (exec_op)
    begin
      flags_r <= alu_res.flags;
    end
    else if (sw_stat)
    begin
      flags_r <= sw_flags;
    end
  end

  // bank select is plain storage; only the status read returns it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_r <= BANK_RST;
    end
    else if (sw_stat)
    begin
      bank_r <= pwdata[ST_BANK_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reg_idx_r <= '0;
    end
    else if (sw_idx)
    begin
      reg_idx_r <= pwdata[REG_AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_val_r  <= ZERO_BYTE;
      last_dest_r <= DEST_ACC;
    end
    else if (exec_op)
    begin
      last_val_r  <= alu_res.value;
      last_dest_r <= alu_res.to_reg;
    end
  end

endmodule : bals_top
`default_nettype wire

//--- verification/bals_top_chk.sv
// assertions on the apb ports of the byte alu slice
// assumes only the ports of bals_top; bound to it at the foot
`timescale 1ns/1ns
`default_nettype none
module bals_chk #(
  parameter int REG_DEPTH = 128
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [bals_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic [31:0]                  prdata,
  input wire logic                         pslverr
);
  import bals_pkg::*;
  wire logic mapped = paddr inside {OFS_CMD, OFS_ACC, OFS_STATUS, OFS_REG_IDX,
                                    OFS_REG_DATA, OFS_RESULT};
  wire logic fast   = paddr inside {OFS_ACC, OFS_STATUS, OFS_REG_IDX, OFS_RESULT};
  wire logic rd_ans = pready && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    !pready ##[1:2] pready;
  endsequence
  ////////////////////////////////////////
  bus_answer_a: assert property (setup_s |=> answer_s)
    else $error("transfer not answered in time");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (setup_s ##0 !mapped |=> !pready ##1 (pready && pslverr))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped register");
  fast_reg_a: assert property (setup_s ##0 fast |=> !pready ##1 pready)
    else $error("plain register wait wrong");
  data_slow_a: assert property (setup_s ##0 (paddr == OFS_REG_DATA) |=> !pready [*2] ##1 pready)
    else $error("register file wait wrong");
  write_zero_a: assert property (pready && pwrite |-> prdata == ZERO_WORD)
    else $error("write returned data");
  status_held_a: assert property (rd_ans && paddr == OFS_STATUS |->
                                  prdata[31:8] == 24'h00_0000 && prdata[4:3] == HELD_RST)
    else $error("status held bits wrong");
  index_width_a: assert property (rd_ans && paddr == OFS_REG_IDX |-> prdata[31:7] == 25'h0)
    else $error("register index too wide");
endmodule : bals_chk

bind bals_top bals_chk #(.REG_DEPTH(REG_DEPTH)) bals_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

//--- verification/byte_alu_sub_xor_swap_test.sv
// self-checking bench for the byte alu slice, driven through apb
// assumes bals_top with its checker bound; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module byte_alu_sub_xor_swap_test;
  import bals_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          mismatches = 0;
  int          n_checks = 0;
  bals_top #(.REG_DEPTH(128)) bals_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait: a slave that never answers ends the run
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 8)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready === 1'b1)
      @(posedge pclk);
    else
    begin
      mismatches++;
      complete_run();
    end
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    cmp({31'h0000_0000, e}, 32'h0000_0000);
  endtask : wr
  // read data of a refused read is not defined, so only the error is compared
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    cmp({31'h0000_0000, e}, {31'h0000_0000, xe});
    if (!xe)
      cmp(r, x);
  endtask : rd_chk
  // loads operands and flags, runs one command, checks every destination
  task automatic run_op(input bals_op_t op, input logic d, input logic [6:0] ra,
                        input logic [7:0] im, input logic [7:0] a, input logic [7:0] r,
                        input logic [2:0] f);
    logic [7:0] res;
    logic [2:0] nf;
    logic       to_reg;
    nf = f;
    case (op)
      subtract_acc_from_register:
      begin
        res = r - a;
        nf  = {res == 8'h00, a[3:0] <= r[3:0], a <= r};
      end
      xor_acc_with_register:
      begin
        res   = a ^ r;
        nf[2] = res == 8'h00;
      end
      nibble_exchange_register:
        res = {r[3:0], r[7:4]};
      default:
      begin
        res   = a ^ im;
        nf[2] = res == 8'h00;
      end
    endcase
    to_reg = d && op != xor_immediate_into_acc;
    wr(OFS_ACC, {24'h00_0000, a});
    wr(OFS_REG_IDX, {25'h000_0000, ra});
    wr(OFS_REG_DATA, {24'h00_0000, r});
    wr(OFS_STATUS, {24'h00_0000, 5'b1010_0, f});
    wr(OFS_CMD, {8'h00, im, 1'b0, ra, 3'b000, d, 2'b00, op});
    rd_chk(OFS_ACC, {24'h00_0000, to_reg ? a : res}, 1'b0);
    rd_chk(OFS_REG_DATA, {24'h00_0000, to_reg ? res : r}, 1'b0);
    rd_chk(OFS_STATUS, {24'h00_0000, 5'b1011_1, nf}, 1'b0);
    rd_chk(OFS_RESULT, {23'h00_0000, to_reg, res}, 1'b0);
  endtask : run_op
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    logic        e;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFS_ACC, 32'h0000_0000, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_0018, 1'b0);
    rd_chk(OFS_RESULT, 32'h0000_0000, 1'b0);
    rd_chk(OFS_CMD, 32'h0000_0000, 1'b0);
    wr(OFS_REG_IDX, 32'h0000_00FF);
    rd_chk(OFS_REG_IDX, 32'h0000_007F, 1'b0);
    rd_chk(12'h018, 32'h0000_0000, 1'b1);
    rd_chk(12'h006, 32'h0000_0000, 1'b1);
    xfer(1'b1, 12'h01C, 32'h0000_00AA, r, e);
    cmp({31'h0000_0000, e}, 32'h0000_0001);
    rd_chk(OFS_ACC, 32'h0000_0000, 1'b0);
    run_op(subtract_acc_from_register, 1'b0, 7'd0, 8'h00, 8'h05, 8'h05, 3'b000);
    run_op(subtract_acc_from_register, 1'b1, 7'd127, 8'h00, 8'h10, 8'h0F, 3'b111);
    run_op(subtract_acc_from_register, 1'b0, 7'd64, 8'h00, 8'h01, 8'h80, 3'b000);
    run_op(xor_acc_with_register, 1'b1, 7'd3, 8'h00, 8'hA5, 8'hA5, 3'b011);
    run_op(xor_acc_with_register, 1'b0, 7'd127, 8'h00, 8'h0F, 8'hF0, 3'b100);
    run_op(nibble_exchange_register, 1'b0, 7'd9, 8'h00, 8'h11, 8'h3C, 3'b101);
    run_op(nibble_exchange_register, 1'b1, 7'd10, 8'h00, 8'h22, 8'h00, 3'b010);
    run_op(xor_immediate_into_acc, 1'b1, 7'd5, 8'hFF, 8'hFF, 8'h44, 3'b011);
    run_op(xor_immediate_into_acc, 1'b0, 7'd5, 8'h5A, 8'h0F, 8'h44, 3'b100);
    wr(OFS_RESULT, 32'h0000_01FF);
    rd_chk(OFS_RESULT, 32'h0000_0055, 1'b0);
    complete_run();
  end
endmodule : byte_alu_sub_xor_swap_test
`default_nettype wire
